//--- logic/cid_top.v
// command interlock distributor with axi4-lite register access
`timescale 1ns/1ps
`include "cid_defs.vh"
// Overview of operation
// RULE1 - pitch loop select also cancels dual motor
// RULE2 - bias polarity powers coil, enables stepping
// RULE3 - position 11 enters high-torque mode
// RULE4 - orbit coil, bias coil powered independently
// RULE5 - high torque: limit current if orbit disabled
// RULE6 - even phase negative, odd phase positive
// RULE7 - momentum coils any combination, commands only
// RULE8 - one polarity for both momentum coils
// RULE9 - drop pulse stops momentum, keeps polarity
// RULE10 - deploy relay follows pulse, bus by decoder
// RULE11 - commander selects transmitter before turn-on
// RULE12 - vidicon selection change ends playback
// RULE13 - no parallel scan playback; dual acts single
// RULE14 - converter off ties buses, pulses radiometer off
// RULE15 - radiometer on pulses converter on, calibration off
// RULE16 - no beacon: commutators off, bus unpowered
// RULE17 - no programmer: scan radiometer off pulse
// RULE18 - real-time select restores full-time mode
// RULE19 - decoder drop gives one forwarded pulse
// RULE20 - drop pulse ends playbacks, transmitter, advance
// RULE21 - tone 20 s turns on commutator
// RULE22 - overflow deselects both real-time transmitters
// RULE23 - each command is one synchronous strobe; deploy and decoder bits drive the outputs as levels
module cid_top #(
  parameter [31:0] TONE_CYCLES = `CID_TONE_S * `CID_CLK_HZ
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire [3:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [3:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  output reg [31:0] STATUS_OUT,
  output reg [15:0] PULSE_OUT
);
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] cmd_word;
  reg [31:0] prg_word;
  wire [31:0] status;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction
  // accept address and data in either order, respond after both
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `CID_RESP_OK;
      cmd_word <= 32'h00000000;
      prg_word <= 32'h00000000;
    end else begin
      AWREADY <= !aw_held && !AWREADY && AWVALID && !BVALID;
      WREADY <= !w_held && !WREADY && WVALID && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (aw_held && w_held && !BVALID) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= `CID_RESP_OK;
        if (aw_addr == `CID_ADDR_CMD)
          cmd_word <= merge(cmd_word, w_data, w_strb);
        else if (aw_addr == `CID_ADDR_PRG)
          prg_word <= merge(prg_word, w_data, w_strb);
        else if (aw_addr != `CID_ADDR_STAT)
          BRESP <= `CID_RESP_ERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  // read channel: one cycle to accept, data next
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `CID_RESP_OK;
    end else begin
      ARREADY <= !ARREADY && ARVALID && !RVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= `CID_RESP_OK;
        case (ARADDR)
          `CID_ADDR_CMD: RDATA <= cmd_word;
          `CID_ADDR_PRG: RDATA <= prg_word;
          `CID_ADDR_STAT: RDATA <= status;
          default: begin
            RDATA <= 32'h00000000;
            RRESP <= `CID_RESP_ERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // command strobes
  // ------------------------------------------------------------
  wire [31:0] cp;
  wire [31:0] pp;
  wire tone_fire1;
  wire tone_fire2;
  // each command bit that rises from 0 to 1 becomes one pulse
  cid_strobe u_cmd (.clk(SYS_CLK), .rst_b(RST_B), .level(cmd_word), .pulse(cp)); // RULE23
  cid_strobe u_prg (.clk(SYS_CLK), .rst_b(RST_B), .level(prg_word), .pulse(pp));
  cid_tone #(.HOLD(TONE_CYCLES)) u_tone1 (
    .clk(SYS_CLK), .rst_b(RST_B), .tone(prg_word[`CID_P_TONE1]), .fire(tone_fire1));
  cid_tone #(.HOLD(TONE_CYCLES)) u_tone2 (
    .clk(SYS_CLK), .rst_b(RST_B), .tone(prg_word[`CID_P_TONE2]), .fire(tone_fire2));
  wire drop = pp[`CID_P_DROP]; // RULE19
  // ------------------------------------------------------------
  // relay state
  // ------------------------------------------------------------
  reg omac_en;
  reg bias_en;
  reg bias_neg;
  reg [`CID_STEP_W-1:0] step_pos;
  reg mom1;
  reg mom2;
  reg mom_neg;
  reg dig_tied;
  reg hk_bus;
  reg comm1;
  reg comm2;
  reg auto_adv;
  reg vid_sel;
  reg vid_play;
  reg scan_play1;
  reg scan_play2;
  reg rt_sel1;
  reg rt_sel2;
  reg hr_tx_on;
  reg manual_adv;
  reg comm_out;
  wire high_torque = (step_pos == `CID_STEP_HIGH); // RULE3
  wire omac_drive = prg_word[`CID_P_EVEN] | prg_word[`CID_P_ODD];
  // attitude coil relays
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      omac_en <= 1'b0;
      bias_en <= 1'b0;
      bias_neg <= 1'b0;
      step_pos <= `CID_STEP_RESET;
      mom1 <= 1'b0;
      mom2 <= 1'b0;
      mom_neg <= 1'b0;
    end else begin
      if (cp[`CID_C_OMAC_EN]) omac_en <= 1'b1; // RULE4
      if (cp[`CID_C_OMAC_DIS]) omac_en <= 1'b0; // RULE4
      if (cp[`CID_C_BIAS_DIS]) bias_en <= 1'b0; // RULE4
      if (cp[`CID_C_BIAS_POS] || cp[`CID_C_BIAS_NEG]) bias_en <= 1'b1; // RULE2
      if (cp[`CID_C_BIAS_POS]) bias_neg <= 1'b0;
      if (cp[`CID_C_BIAS_NEG]) bias_neg <= 1'b1;
      if (high_torque && pp[`CID_P_EVEN]) bias_neg <= 1'b1; // RULE6
      if (high_torque && pp[`CID_P_ODD]) bias_neg <= 1'b0; // RULE6
      if (cp[`CID_C_BIAS_STEP] && bias_en) // RULE2
        step_pos <= (step_pos == `CID_STEP_MAX) ? `CID_STEP_RESET : step_pos + 4'h1;
      if (cp[`CID_C_MOM1_ON]) mom1 <= 1'b1; // RULE7
      if (cp[`CID_C_MOM2_ON]) mom2 <= 1'b1; // RULE7
      if (cp[`CID_C_MOM_DIS] || drop) begin
        mom1 <= 1'b0; // RULE9
        mom2 <= 1'b0;
      end
      if (cp[`CID_C_MOM_POS]) mom_neg <= 1'b0; // RULE8
      if (cp[`CID_C_MOM_NEG]) mom_neg <= 1'b1; // RULE8
    end
  end
  // recorder, telemetry and transmitter relays
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dig_tied <= 1'b1;
      hk_bus <= 1'b0;
      comm1 <= 1'b0;
      comm2 <= 1'b0;
      auto_adv <= 1'b0;
      vid_sel <= 1'b0;
      vid_play <= 1'b0;
      scan_play1 <= 1'b0;
      scan_play2 <= 1'b0;
      rt_sel1 <= 1'b0;
      rt_sel2 <= 1'b0;
      hr_tx_on <= 1'b0;
      manual_adv <= 1'b0;
      comm_out <= 1'b0;
    end else begin
      if (cp[`CID_C_DFC_ON] || cp[`CID_C_FPR_ON]) dig_tied <= 1'b0;
      if (cp[`CID_C_DFC_OFF]) dig_tied <= 1'b1; // RULE14
      if (cp[`CID_C_BEACON_NONE]) begin
        comm1 <= 1'b0; // RULE16
        comm2 <= 1'b0;
        hk_bus <= 1'b0;
      end
      if (tone_fire1 || tone_fire2) begin
        auto_adv <= 1'b1; // RULE21
        hk_bus <= 1'b1;
        comm_out <= 1'b1;
      end
      if (tone_fire1 && prg_word[`CID_P_BEACON1]) comm1 <= 1'b1; // RULE21
      if (tone_fire2 && prg_word[`CID_P_BEACON2]) comm2 <= 1'b1; // RULE21
      if (cp[`CID_C_VID_SEL]) vid_sel <= ~vid_sel;
      if (cp[`CID_C_VID_PLAY] && hr_tx_on) vid_play <= 1'b1;
      if (cp[`CID_C_VID_SEL]) vid_play <= 1'b0; // RULE12
      // only one scan recorder plays; dual with one selected acts single
      if (!scan_play1 && !scan_play2) begin
        if ((cp[`CID_C_SCAN_PLAY1] || cp[`CID_C_SCAN_PLAYB]) && prg_word[`CID_P_SCAN_SEL1])
          scan_play1 <= hr_tx_on; // RULE13
        else if ((cp[`CID_C_SCAN_PLAY2] || cp[`CID_C_SCAN_PLAYB]) && prg_word[`CID_P_SCAN_SEL2])
          scan_play2 <= hr_tx_on; // RULE13
      end
      if (cp[`CID_C_RT_TX1]) begin
        rt_sel1 <= 1'b1;
        rt_sel2 <= 1'b0;
      end
      if (cp[`CID_C_RT_TX2]) begin
        rt_sel2 <= 1'b1;
        rt_sel1 <= 1'b0;
      end
      if (pp[`CID_P_OVERFLOW]) begin
        rt_sel1 <= 1'b0; // RULE22
        rt_sel2 <= 1'b0;
      end
      if (prg_word[`CID_P_SCAN_SEL1] && prg_word[`CID_P_SCAN_SEL2]) hr_tx_on <= 1'b1;
      if (cp[`CID_C_SCAN_EN2]) manual_adv <= 1'b1;
      if (drop) begin
        vid_play <= 1'b0; // RULE20
        scan_play1 <= 1'b0;
        scan_play2 <= 1'b0;
        hr_tx_on <= 1'b0;
        manual_adv <= 1'b0;
        comm_out <= 1'b0;
      end
    end
  end
  assign status = {7'h00, comm_out, manual_adv, hr_tx_on, rt_sel2, rt_sel1,
    scan_play2, scan_play1, vid_play, vid_sel, auto_adv, comm2, comm1, hk_bus,
    dig_tied, mom_neg, mom2, mom1, step_pos, bias_neg, bias_en, omac_en, high_torque};
  // ------------------------------------------------------------
  // output registers and derived pulses
  // ------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      STATUS_OUT <= 32'h00000000;
      PULSE_OUT <= 16'h0000;
    end else begin
      STATUS_OUT <= status;
      PULSE_OUT[0] <= cp[`CID_C_PITCH1] | cp[`CID_C_PITCH2]; // RULE1
      PULSE_OUT[1] <= cmd_word[`CID_C_DEPLOY] & ~cmd_word[`CID_C_DECODER2]; // RULE10
      PULSE_OUT[2] <= cmd_word[`CID_C_DEPLOY] & cmd_word[`CID_C_DECODER2]; // RULE10
      PULSE_OUT[3] <= cp[`CID_C_DFC_OFF]; // RULE14
      PULSE_OUT[4] <= cp[`CID_C_FPR_ON]; // RULE15
      PULSE_OUT[5] <= cp[`CID_C_FPR_ON]; // RULE15
      PULSE_OUT[6] <= cp[`CID_C_PROG_NONE]; // RULE17
      PULSE_OUT[7] <= cp[`CID_C_RT_TX1] | cp[`CID_C_RT_TX2]; // RULE18
      PULSE_OUT[8] <= drop; // RULE19
      PULSE_OUT[9] <= drop; // RULE20
      // bias coil drive: direct, or current-limited in high torque with orbit disabled
      PULSE_OUT[10] <= bias_en & (high_torque ? (omac_drive & omac_en) : 1'b1); // RULE5
      PULSE_OUT[11] <= bias_en & high_torque & omac_drive & ~omac_en; // RULE5
      PULSE_OUT[12] <= omac_en & omac_drive;
      PULSE_OUT[13] <= mom1;
      PULSE_OUT[14] <= mom2;
      PULSE_OUT[15] <= cp[`CID_C_DFC_ON] | cp[`CID_C_FPR_ON];
    end
  end
endmodule // cid_top

//--- logic/cid_defs.vh
// constants for the command interlock distributor
`ifndef CID_DEFS_VH
`define CID_DEFS_VH
// register byte offsets
`define CID_ADDR_CMD 4'h0
`define CID_ADDR_STAT 4'h4
`define CID_ADDR_PRG 4'h8
// command word bit positions
`define CID_C_PITCH1 0
`define CID_C_PITCH2 1
`define CID_C_OMAC_EN 2
`define CID_C_OMAC_DIS 3
`define CID_C_BIAS_POS 4
`define CID_C_BIAS_NEG 5
`define CID_C_BIAS_DIS 6
`define CID_C_BIAS_STEP 7
`define CID_C_MOM1_ON 8
`define CID_C_MOM2_ON 9
`define CID_C_MOM_DIS 10
`define CID_C_MOM_POS 11
`define CID_C_MOM_NEG 12
`define CID_C_DEPLOY 13
`define CID_C_DFC_ON 14
`define CID_C_DFC_OFF 15
`define CID_C_FPR_ON 16
`define CID_C_BEACON_NONE 17
`define CID_C_PROG_NONE 18
`define CID_C_RT_TX1 19
`define CID_C_RT_TX2 20
`define CID_C_VID_SEL 21
`define CID_C_VID_PLAY 22
`define CID_C_SCAN_PLAY1 23
`define CID_C_SCAN_PLAY2 24
`define CID_C_SCAN_PLAYB 25
`define CID_C_SCAN_EN2 26
`define CID_C_DECODER2 31
// programmer/input word bit positions
`define CID_P_EVEN 0
`define CID_P_ODD 1
`define CID_P_DROP 2
`define CID_P_TONE1 3
`define CID_P_TONE2 4
`define CID_P_BEACON1 5
`define CID_P_BEACON2 6
`define CID_P_OVERFLOW 7
`define CID_P_SCAN_SEL1 8
`define CID_P_SCAN_SEL2 9
// stepping switch
`define CID_STEP_W 4
`define CID_STEP_HIGH 4'hB
`define CID_STEP_MAX 4'hB
`define CID_STEP_RESET 4'h0
// tone hold: 20 s at 25 MHz, parameter default
`define CID_TONE_S 20
`define CID_CLK_HZ 25000000
// axi responses
`define CID_RESP_OK 2'h0
`define CID_RESP_ERR 2'h2
`endif

//--- logic/cid_strobe.v
// one-shot strobe generator for command bits
`timescale 1ns/1ps
module cid_strobe (
  input wire clk,
  input wire rst_b,
  input wire [31:0] level,
  output reg [31:0] pulse
);
  reg [31:0] prev;
  // rising edge to one-cycle pulse
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 32'h00000000;
      pulse <= 32'h00000000;
    end else begin
      prev <= level;
      pulse <= level & ~prev;
    end
  end
endmodule // cid_strobe

//--- logic/cid_tone.v
// tone persistence timer
`timescale 1ns/1ps
module cid_tone #(
  parameter [31:0] HOLD = 32'd500000000
) (
  input wire clk,
  input wire rst_b,
  input wire tone,
  output reg fire
);
  reg [31:0] cnt;
  // count steady tone, fire once when held long enough
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 32'h00000000;
      fire <= 1'b0;
    end else begin
      fire <= tone && (cnt == HOLD - 32'h00000001);
      if (!tone)
        cnt <= 32'h00000000;
      else if (cnt != HOLD)
        cnt <= cnt + 32'h00000001;
    end
  end
endmodule // cid_tone

//--- tb/cid_sink.sv
// far-side model: the subsystems that receive the command pulses
`timescale 1ns/1ps
module cid_sink (
  input wire clk,
  input wire [15:0] pulse
);
  // ---------------------------
  // pulse counting
  // ---------------------------
  int cnt [16];
  logic [15:0] last = 16'h0000;
  // each 0-to-1 change on a line counts as one received command
  always @(posedge clk) begin
    last <= pulse;
    for (int i = 0; i < 16; i++) begin
      if (pulse[i] && !last[i]) cnt[i]++;
    end
  end
endmodule // cid_sink

//--- tb/cid_top_assertions.sv
// port checker for the command interlock distributor
`timescale 1ns/1ps
`include "cid_defs.vh"
module cid_top_assertions #(
  parameter [31:0] TONE_CYCLES = 32'h0000000A
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire [3:0] AWADDR,
  input wire AWVALID,
  input wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  input wire WREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire [3:0] ARADDR,
  input wire ARVALID,
  input wire ARREADY,
  input wire [31:0] RDATA,
  input wire [1:0] RRESP,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] STATUS_OUT,
  input wire [15:0] PULSE_OUT
);
  // ---------------------------
  // checks
  // ---------------------------
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  // bus handshakes as steps
  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_rd_taken;
    ARVALID && ARREADY;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##[1:3] BVALID)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_taken |-> ##[1:2] RVALID)
    else $error("read response missing");
  a_ready_once: assert property (AWREADY |=> !AWREADY)
    else $error("address ready held");
  a_torque_pos: assert property (STATUS_OUT[0] == (STATUS_OUT[7:4] == `CID_STEP_HIGH))
    else $error("high torque not tied to step");
  a_drive_excl: assert property (!(PULSE_OUT[10] && PULSE_OUT[11]))
    else $error("direct and limited together");
  a_squib_excl: assert property (!(PULSE_OUT[1] && PULSE_OUT[2]))
    else $error("both squib buses");
  a_cancel_once: assert property (PULSE_OUT[0] |=> !PULSE_OUT[0])
    else $error("cancel pulse too long");
  a_drop_once: assert property (PULSE_OUT[8] |=> !PULSE_OUT[8])
    else $error("drop pulse too long");
  a_drop_stops: assert property (PULSE_OUT[8] |-> ##[0:3] (STATUS_OUT[9:8] == 2'h0))
    else $error("momentum coils left on");
endmodule // cid_top_assertions
bind cid_top cid_top_assertions #(.TONE_CYCLES(TONE_CYCLES)) u_chk (.*);

//--- tb/tb.sv
// self-checking bench for the command interlock distributor
`timescale 1ns/1ps
`include "cid_defs.vh"
module tb;
  // ---------------------------
  // signals and instances
  // ---------------------------
  localparam int TC = 10;
  logic SYS_CLK = 1'h0;
  logic RST_B = 1'h0;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, rsp;
  logic [31:0] WDATA = 32'h0, RDATA, STATUS_OUT, rd;
  logic [15:0] PULSE_OUT;
  int errors = 0, cmp_count = 0;
  cid_top #(.TONE_CYCLES(TC)) u_dut (.*);
  cid_sink u_sink (.clk(SYS_CLK), .pulse(PULSE_OUT));
  always #20 SYS_CLK = ~SYS_CLK;
  // ---------------------------
  // helpers
  // ---------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic sb(input string n, input int b, input logic e);
    chk(n, {31'h0, e}, {31'h0, STATUS_OUT[b]});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
    end while (!BVALID && n < 50);
    if (n >= 50) errors++;
    rsp = BRESP;
    BREADY <= 1'h0;
    repeat (3) @(posedge SYS_CLK);
  endtask
  task automatic rdw(input logic [3:0] a);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (ARREADY) ARVALID <= 1'h0;
    end while (!RVALID && n < 50);
    if (n >= 50) errors++;
    rd = RDATA;
    rsp = RRESP;
    RREADY <= 1'h0;
    @(posedge SYS_CLK);
  endtask
  task automatic cmd(input int b);
    wr(`CID_ADDR_CMD, 32'h1 << b);
    wr(`CID_ADDR_CMD, 32'h0);
  endtask
  task automatic pcase(input int c, input int p, input int q);
    int b [16];
    b = u_sink.cnt;
    cmd(c);
    chk("pulse p", b[p] + 1, u_sink.cnt[p]);
    chk("pulse q", b[q] + 1, u_sink.cnt[q]);
  endtask
  // ---------------------------
  // scenarios
  // ---------------------------
  task automatic t_regs();
    rdw(`CID_ADDR_STAT);
    chk("status reset", 32'h00000800, rd);
    rdw(4'hC);
    chk("rd unmapped", {30'h0, `CID_RESP_ERR}, {30'h0, rsp});
    wr(4'hC, 32'hFFFFFFFF);
    chk("wr unmapped", {30'h0, `CID_RESP_ERR}, {30'h0, rsp});
    wr(`CID_ADDR_STAT, 32'hFFFFFFFF);
    rdw(`CID_ADDR_STAT);
    chk("status kept", 32'h00000800, rd);
    $display("test regs done");
  endtask
  task automatic t_bias();
    cmd(`CID_C_BIAS_STEP);
    chk("step locked", 32'h0, {28'h0, STATUS_OUT[7:4]});
    cmd(`CID_C_BIAS_POS);
    sb("bias on", 2, 1'h1);
    repeat (11) cmd(`CID_C_BIAS_STEP);
    chk("step pos", 32'hB, {28'h0, STATUS_OUT[7:4]});
    cmd(`CID_C_OMAC_DIS);
    sb("bias kept", 2, 1'h1);
    sb("orbit off", 1, 1'h0);
    wr(`CID_ADDR_PRG, 32'h1);
    sb("even neg", 3, 1'h1);
    chk("limited", 32'h800, {16'h0, PULSE_OUT} & 32'hC00);
    cmd(`CID_C_OMAC_EN);
    chk("direct", 32'h400, {16'h0, PULSE_OUT} & 32'hC00);
    wr(`CID_ADDR_PRG, 32'h2);
    sb("odd pos", 3, 1'h0);
    chk("no mom", 32'h0, STATUS_OUT & 32'h300);
    wr(`CID_ADDR_PRG, 32'h0);
    cmd(`CID_C_BIAS_STEP);
    sb("wrapped", 0, 1'h0);
    $display("test bias done");
  endtask
  task automatic t_mom();
    cmd(`CID_C_MOM1_ON);
    chk("mom1", 32'h100, STATUS_OUT & 32'h700);
    cmd(`CID_C_MOM2_ON);
    cmd(`CID_C_MOM_NEG);
    chk("both neg", 32'h700, STATUS_OUT & 32'h700);
    chk("coil drive", 32'h6000, {16'h0, PULSE_OUT} & 32'h6000);
    cmd(`CID_C_SCAN_EN2);
    wr(`CID_ADDR_PRG, 32'h4);
    chk("drop", 32'h400, STATUS_OUT & 32'h700);
    sb("adv reset", 23, 1'h0);
    chk("drop fwd", 32'h1, u_sink.cnt[8]);
    wr(`CID_ADDR_PRG, 32'h0);
    $display("test momentum done");
  endtask
  task automatic t_play();
    wr(`CID_ADDR_PRG, 32'h300);
    sb("tx on", 22, 1'h1);
    cmd(`CID_C_VID_PLAY);
    sb("vid play", 17, 1'h1);
    cmd(`CID_C_VID_SEL);
    sb("vid ended", 17, 1'h0);
    wr(`CID_ADDR_PRG, 32'h100);
    cmd(`CID_C_SCAN_PLAYB);
    chk("dual single", 32'h40000, STATUS_OUT & 32'hC0000);
    wr(`CID_ADDR_PRG, 32'h300);
    cmd(`CID_C_SCAN_PLAYB);
    chk("no parallel", 32'h40000, STATUS_OUT & 32'hC0000);
    wr(`CID_ADDR_PRG, 32'h304);
    chk("drop ends", 32'h0, STATUS_OUT & 32'hE0000);
    wr(`CID_ADDR_PRG, 32'h0);
    $display("test playback done");
  endtask
  task automatic t_misc();
    pcase(`CID_C_PITCH1, 0, 0);
    pcase(`CID_C_PITCH2, 0, 0);
    cmd(`CID_C_DFC_ON);
    pcase(`CID_C_DFC_OFF, 3, 3);
    sb("bus tied", 11, 1'h1);
    pcase(`CID_C_FPR_ON, 4, 5);
    pcase(`CID_C_PROG_NONE, 6, 6);
    pcase(`CID_C_RT_TX2, 7, 7);
    pcase(`CID_C_RT_TX1, 7, 7);
    wr(`CID_ADDR_PRG, 32'h80);
    chk("rt off", 32'h0, STATUS_OUT & 32'h300000);
    wr(`CID_ADDR_CMD, 32'h2000);
    chk("bus1", 32'h2, {16'h0, PULSE_OUT} & 32'h6);
    wr(`CID_ADDR_CMD, 32'h80002000);
    chk("bus2", 32'h4, {16'h0, PULSE_OUT} & 32'h6);
    wr(`CID_ADDR_CMD, 32'h0);
    chk("relay off", 32'h0, {16'h0, PULSE_OUT} & 32'h6);
    wr(`CID_ADDR_PRG, 32'h28);
    repeat (TC + 5) @(posedge SYS_CLK);
    chk("tone", 32'hB000, STATUS_OUT & 32'hF000);
    wr(`CID_ADDR_PRG, 32'h10);
    repeat (TC + 5) @(posedge SYS_CLK);
    sb("no comm2", 14, 1'h0);
    wr(`CID_ADDR_PRG, 32'h0);
    cmd(`CID_C_BEACON_NONE);
    chk("beacon none", 32'h0, STATUS_OUT & 32'h7000);
    $display("test interlocks done");
  endtask
  // ---------------------------
  // run control
  // ---------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence after 5 cycles of reset
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST_B <= 1'h1;
    @(posedge SYS_CLK);
    t_regs();
    t_bias();
    t_mom();
    t_play();
    t_misc();
    summarize();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    errors++;
    summarize();
  end
endmodule // tb
